// ---- mbs_pkg.sv ----
// Constants and carriers for the serial slave status and exception block.
// Assumes one 200 MHz clock; the link framing is decoded outside.
package mbs_pkg;
   // Register addresses
   localparam logic [15:0] ADDR_STATUS    = 16'h2226;
   localparam logic [15:0] ADDR_TORQUE    = 16'h2227;
   localparam logic [15:0] ADDR_ENERGY    = 16'h2229;
   localparam logic [15:0] ADDR_LOOP_TGT  = 16'h222E;
   localparam logic [15:0] ADDR_LOOP_OFS  = 16'h222F;
   localparam logic [15:0] ADDR_LOOP_FRQ  = 16'h2230;
   localparam logic [15:0] ADDR_AUX_FRQ   = 16'h2232;
   localparam logic [15:0] ADDR_MAS_FRQ   = 16'h2233;
   localparam logic [15:0] ADDR_COMB_FRQ  = 16'h2234;
   localparam logic [15:0] ADDR_DELAY     = 16'h0909;
   localparam logic [15:0] ADDR_FREQ      = 16'h090A;
   // Settings: delay in 0.1 ms steps, frequency in 0.01 Hz steps
   localparam logic [15:0] RST_DELAY      = 16'h0014;
   localparam logic [15:0] MAX_DELAY      = 16'h07D0;
   localparam logic [15:0] RST_FREQ       = 16'h1770;
   localparam logic [15:0] MAX_FREQ       = 16'hE9FC;
   // Status word field positions
   localparam int          ST_DIR_LSB     = 0;
   localparam int          ST_RDY_LSB     = 2;
   localparam int          ST_OUT_BIT     = 4;
   localparam int          ST_WARN_BIT    = 5;
   // Function and exception codes
   localparam logic [7:0]  FC_READ        = 8'h03;
   localparam logic [7:0]  FC_WRITE       = 8'h06;
   localparam logic [7:0]  FC_EXC_FLAG    = 8'h80;
   localparam logic [7:0]  RD_BYTE_COUNT  = 8'h02;
   localparam logic [7:0]  EXC_NONE       = 8'h00;
   localparam logic [7:0]  EXC_FUNC       = 8'h01;
   localparam logic [7:0]  EXC_ADDR       = 8'h02;
   localparam logic [7:0]  EXC_DATA       = 8'h03;
   localparam logic [7:0]  EXC_FAIL       = 8'h04;
   localparam logic [7:0]  ERR_CRC        = 8'h05;
   localparam logic [3:0]  FSRC_COMM      = 4'h1;
   localparam logic [15:0] CRC_INIT       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'hA001;
   // Timing
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          DELAY_STEP_US  = 100;
   localparam int          DELAY_STEP_CYC = DELAY_STEP_US * 1000
                                            / CLK_PERIOD_NS;
   localparam int          BUF_BYTES      = 6;

   typedef struct packed {
      logic [7:0]  slave;
      logic [7:0]  func;
      logic [15:0] reg_addr;
      logic [15:0] data;
      logic        crc_err;
   } mbs_req_t;

   typedef struct packed {
      logic [1:0]  dir;
      logic [1:0]  rdy;
      logic        out_active;
      logic        warn;
      logic [15:0] torque;
      logic [15:0] energy;
      logic [15:0] loop_tgt;
      logic [15:0] loop_ofs;
      logic [15:0] loop_frq;
      logic [15:0] aux_frq;
      logic [15:0] mas_frq;
      logic [15:0] comb_frq;
   } mbs_mon_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_SEND = 3'b100
   } mbs_state_t;
endpackage

// ---- mbs_slave.sv ----
// Serial slave command interpreter: monitor reads, settings, exceptions.
// Assumes requests arrive already deframed; replies leave byte by byte.
//
// What this block does
// - The status word packs direction, ready/error, output and warning.
// - Signed estimated torque reads at the address after the status word.
// - A refused request is answered with the function code's top bit set.
// - Code 1 marks an unknown function, code 2 an unknown address.
// - Code 3 marks bad data, code 4 a function that could not be done.
// - A communication error on a frame for this node that arrives while idle raises a warning carrying its code.
// - The reply waits a set delay of 0 to 200 ms, 2.0 ms by default.
// - With the serial source set the stored frequency survives power loss.
// - After power returns the drive runs from the stored frequency.
// - With the serial source set, each frequency write updates the stored value, 0 to 599 Hz.
`timescale 1ns/1ps
module mbs_slave #(
   parameter int TICK_CYCLES = mbs_pkg::DELAY_STEP_CYC
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // Configuration
   input  wire logic [7:0]       i_node_addr,
   input  wire logic [3:0]       i_freq_src,
   // Retained frequency from backup storage
   input  wire logic             i_nv_valid,
   input  wire logic [15:0]      i_nv_freq,
   // Drive monitor values
   input  wire mbs_pkg::mbs_mon_t i_mon,
   // Decoded request
   input  wire logic             i_req_valid,
   input  wire mbs_pkg::mbs_req_t i_req,
   output logic                  o_busy,
   // Reply byte stream
   output logic                  o_tx_valid,
   output logic [7:0]            o_tx_data,
   output logic                  o_tx_last,
   input  wire logic             i_tx_ready,
   // Drive side results
   output logic                  o_comm_warn,
   output logic [7:0]            o_comm_err_code,
   output logic [15:0]           o_freq_cmd,
   output logic [15:0]           o_nv_freq
);
   mbs_pkg::mbs_state_t state_ff;
   logic [7:0]          buf_ff [mbs_pkg::BUF_BYTES];
   logic [2:0]          len_ff;
   logic [3:0]          idx_ff;
   logic [15:0]         crc_ff;
   logic [15:0]         delay_ff;
   logic [15:0]         tick_ff;
   logic [15:0]         dly_cnt_ff;
   logic                restored_ff;
   logic [15:0]         rd_val;
   logic                rd_ok;
   logic [7:0]          exc;
   logic                take;
   logic                bad_crc;
   logic                tx_step;
   logic                tick;

   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0]  b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ mbs_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   assign take    = (state_ff == mbs_pkg::ST_IDLE) && i_req_valid &&
                    (i_req.slave == i_node_addr) && !i_req.crc_err;
   assign bad_crc = (state_ff == mbs_pkg::ST_IDLE) && i_req_valid &&
                    (i_req.slave == i_node_addr) && i_req.crc_err;
   assign tx_step = !o_tx_valid || i_tx_ready;
   assign tick    = (tick_ff == 16'(TICK_CYCLES - 1));

   // Read map and request checks
   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 16'h0000;
      case (i_req.reg_addr)
         mbs_pkg::ADDR_STATUS:   rd_val = {10'h000, i_mon.warn,
            i_mon.out_active, i_mon.rdy, i_mon.dir};
         mbs_pkg::ADDR_TORQUE:   rd_val = i_mon.torque;
         mbs_pkg::ADDR_ENERGY:   rd_val = i_mon.energy;
         mbs_pkg::ADDR_LOOP_TGT: rd_val = i_mon.loop_tgt;
         mbs_pkg::ADDR_LOOP_OFS: rd_val = i_mon.loop_ofs;
         mbs_pkg::ADDR_LOOP_FRQ: rd_val = i_mon.loop_frq;
         mbs_pkg::ADDR_AUX_FRQ:  rd_val = i_mon.aux_frq;
         mbs_pkg::ADDR_MAS_FRQ:  rd_val = i_mon.mas_frq;
         mbs_pkg::ADDR_COMB_FRQ: rd_val = i_mon.comb_frq;
         mbs_pkg::ADDR_DELAY:    rd_val = delay_ff;
         mbs_pkg::ADDR_FREQ:     rd_val = o_nv_freq;
         default:                rd_ok  = 1'b0;
      endcase
      exc = mbs_pkg::EXC_NONE;
      if (i_req.func == mbs_pkg::FC_READ) begin
         if (!rd_ok)
            exc = mbs_pkg::EXC_ADDR;
         else if (i_req.data != 16'h0001)
            exc = mbs_pkg::EXC_DATA;
      end else if (i_req.func == mbs_pkg::FC_WRITE) begin
         if (i_req.reg_addr == mbs_pkg::ADDR_DELAY) begin
            if (i_req.data > mbs_pkg::MAX_DELAY)
               exc = mbs_pkg::EXC_DATA;
         end else if (i_req.reg_addr == mbs_pkg::ADDR_FREQ) begin
            if (i_req.data > mbs_pkg::MAX_FREQ)
               exc = mbs_pkg::EXC_DATA;
            else if (i_freq_src != mbs_pkg::FSRC_COMM)
               exc = mbs_pkg::EXC_FAIL;
         end else if (rd_ok) begin
            exc = mbs_pkg::EXC_FAIL;
         end else begin
            exc = mbs_pkg::EXC_ADDR;
         end
      end else begin
         exc = mbs_pkg::EXC_FUNC;
      end
   end

   // Sequencing and reply buffer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= mbs_pkg::ST_IDLE;
         len_ff   <= 3'h0;
         for (int i = 0; i < mbs_pkg::BUF_BYTES; i++) begin
            buf_ff[i] <= 8'h00;
         end
      end else begin
         case (state_ff)
            mbs_pkg::ST_IDLE: begin
               if (take) begin
                  state_ff  <= mbs_pkg::ST_WAIT;
                  buf_ff[0] <= i_node_addr;
                  if (exc != mbs_pkg::EXC_NONE) begin
                     buf_ff[1] <= i_req.func | mbs_pkg::FC_EXC_FLAG;
                     buf_ff[2] <= exc;
                     len_ff    <= 3'h3;
                  end else if (i_req.func == mbs_pkg::FC_READ) begin
                     buf_ff[1] <= i_req.func;
                     buf_ff[2] <= mbs_pkg::RD_BYTE_COUNT;
                     buf_ff[3] <= rd_val[15:8];
                     buf_ff[4] <= rd_val[7:0];
                     len_ff    <= 3'h5;
                  end else begin
                     buf_ff[1] <= i_req.func;
                     buf_ff[2] <= i_req.reg_addr[15:8];
                     buf_ff[3] <= i_req.reg_addr[7:0];
                     buf_ff[4] <= i_req.data[15:8];
                     buf_ff[5] <= i_req.data[7:0];
                     len_ff    <= 3'h6;
                  end
               end
            end
            mbs_pkg::ST_WAIT: begin
               if (dly_cnt_ff >= delay_ff)
                  state_ff <= mbs_pkg::ST_SEND;
            end
            mbs_pkg::ST_SEND: begin
               if (o_tx_valid && i_tx_ready && o_tx_last)
                  state_ff <= mbs_pkg::ST_IDLE;
            end
            default: state_ff <= mbs_pkg::ST_IDLE;
         endcase
      end
   end

   // Response delay timing
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_ff    <= 16'h0000;
         dly_cnt_ff <= 16'h0000;
      end else if (state_ff != mbs_pkg::ST_WAIT) begin
         tick_ff    <= 16'h0000;
         dly_cnt_ff <= 16'h0000;
      end else begin
         tick_ff <= tick ? 16'h0000 : tick_ff + 16'h0001;
         if (tick)
            dly_cnt_ff <= dly_cnt_ff + 16'h0001;
      end
   end

   // Reply byte stream with trailing CRC, low byte first
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
         o_tx_last  <= 1'b0;
         idx_ff     <= 4'h0;
         crc_ff     <= mbs_pkg::CRC_INIT;
         o_busy     <= 1'b0;
      end else begin
         o_busy <= (state_ff != mbs_pkg::ST_IDLE) || take;
         if (state_ff != mbs_pkg::ST_SEND) begin
            idx_ff <= 4'h0;
            crc_ff <= mbs_pkg::CRC_INIT;
         end else if (tx_step) begin
            idx_ff <= idx_ff + 4'h1;
            if (idx_ff < {1'b0, len_ff}) begin
               o_tx_valid <= 1'b1;
               o_tx_data  <= buf_ff[idx_ff[2:0]];
               crc_ff     <= crc_upd(crc_ff, buf_ff[idx_ff[2:0]]);
            end else if (idx_ff == {1'b0, len_ff}) begin
               o_tx_data <= crc_ff[7:0];
            end else if (idx_ff == {1'b0, len_ff} + 4'h1) begin
               o_tx_data <= crc_ff[15:8];
               o_tx_last <= 1'b1;
            end else begin
               o_tx_valid <= 1'b0;
               o_tx_last  <= 1'b0;
            end
         end
      end
   end

   // Settings, retained frequency and run command
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         delay_ff    <= mbs_pkg::RST_DELAY;
         o_nv_freq   <= mbs_pkg::RST_FREQ;
         o_freq_cmd  <= mbs_pkg::RST_FREQ;
         restored_ff <= 1'b0;
      end else begin
         restored_ff <= 1'b1;
         if (take && exc == mbs_pkg::EXC_NONE &&
             i_req.func == mbs_pkg::FC_WRITE &&
             i_req.reg_addr == mbs_pkg::ADDR_DELAY)
            delay_ff <= i_req.data;
         if (take && exc == mbs_pkg::EXC_NONE &&
             i_req.func == mbs_pkg::FC_WRITE &&
             i_req.reg_addr == mbs_pkg::ADDR_FREQ)
            o_nv_freq <= i_req.data;
         else if (!restored_ff && i_nv_valid &&
                  i_freq_src == mbs_pkg::FSRC_COMM)
            o_nv_freq <= i_nv_freq;
         o_freq_cmd <= o_nv_freq;
      end
   end

   // Communication warning
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_comm_warn     <= 1'b0;
         o_comm_err_code <= 8'h00;
      end else if (bad_crc) begin
         o_comm_warn     <= 1'b1;
         o_comm_err_code <= mbs_pkg::ERR_CRC;
      end else if (take) begin
         o_comm_warn     <= (exc != mbs_pkg::EXC_NONE);
         o_comm_err_code <= exc;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_status_word;
      take && exc == mbs_pkg::EXC_NONE && i_req.func == mbs_pkg::FC_READ &&
      i_req.reg_addr == mbs_pkg::ADDR_STATUS |=> buf_ff[4][5:0] ==
      {$past(i_mon.warn), $past(i_mon.out_active), $past(i_mon.rdy),
       $past(i_mon.dir)};
   endproperty
   a_status_word: assert property (p_status_word)
      else $error("status word fields misplaced");

   property p_torque;
      take && exc == mbs_pkg::EXC_NONE && i_req.func == mbs_pkg::FC_READ &&
      i_req.reg_addr == mbs_pkg::ADDR_TORQUE |=>
      {buf_ff[3], buf_ff[4]} == $past(i_mon.torque);
   endproperty
   a_torque: assert property (p_torque)
      else $error("torque read wrong");

   property p_exc_flag;
      take && exc != mbs_pkg::EXC_NONE |=> buf_ff[1][7] && len_ff == 3'h3;
   endproperty
   a_exc_flag: assert property (p_exc_flag)
      else $error("exception function flag missing");

   property p_exc_func;
      take && i_req.func != mbs_pkg::FC_READ &&
      i_req.func != mbs_pkg::FC_WRITE |=> buf_ff[2] == mbs_pkg::EXC_FUNC;
   endproperty
   a_exc_func: assert property (p_exc_func)
      else $error("unknown function not code 1");

   property p_exc_data;
      take && i_req.func == mbs_pkg::FC_WRITE &&
      i_req.reg_addr == mbs_pkg::ADDR_FREQ && i_req.data > mbs_pkg::MAX_FREQ
      |=> buf_ff[2] == mbs_pkg::EXC_DATA && o_nv_freq == $past(o_nv_freq);
   endproperty
   a_exc_data: assert property (p_exc_data)
      else $error("bad frequency not code 3");

   property p_warn;
      take && exc != mbs_pkg::EXC_NONE |=>
      o_comm_warn && o_comm_err_code == $past(exc);
   endproperty
   a_warn: assert property (p_warn)
      else $error("warning not raised");

   property p_delay_zero;
      state_ff == mbs_pkg::ST_WAIT && delay_ff == 16'h0000 |=>
      state_ff == mbs_pkg::ST_SEND ##1 o_tx_valid;
   endproperty
   a_delay_zero: assert property (p_delay_zero)
      else $error("zero delay reply late");

   property p_freq_store;
      take && exc == mbs_pkg::EXC_NONE && i_req.func == mbs_pkg::FC_WRITE &&
      i_req.reg_addr == mbs_pkg::ADDR_FREQ |=>
      o_nv_freq == $past(i_req.data) ##1 o_freq_cmd == $past(i_req.data, 2);
   endproperty
   a_freq_store: assert property (p_freq_store)
      else $error("stored frequency not updated");
endmodule // mbs_slave

// ---- mbs_host_model.sv ----
// Host side of the reply stream: collects reply bytes from the slave.
// Assumes bytes are held by the slave until ready is seen high.
`timescale 1ns/1ps
module mbs_host_model (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Reply stream from the slave
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_last,
   // Stall control from the bench
   input  wire logic       i_slow,
   output logic            o_tx_ready
);
   logic [7:0]  rx_b_ff [0:255];
   logic [7:0]  rx_n_ff;
   logic [7:0]  last_ff;
   logic [15:0] lfsr_ff;

   // Pseudo-random stalls when slow, otherwise always ready
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lfsr_ff    <= 16'hACE1;
         o_tx_ready <= 1'b1;
      end else begin
         lfsr_ff    <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^
                        lfsr_ff[12] ^ lfsr_ff[10]};
         o_tx_ready <= i_slow ? lfsr_ff[0] : 1'b1;
      end
   end

   // Byte capture, with the position of the flagged last byte
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_n_ff <= 8'h00;
         last_ff <= 8'h00;
      end else if (i_tx_valid && o_tx_ready) begin
         rx_b_ff[rx_n_ff] <= i_tx_data;
         rx_n_ff          <= rx_n_ff + 8'h01;
         if (i_tx_last) begin
            last_ff <= rx_n_ff;
         end
      end
   end
endmodule // mbs_host_model

// ---- drive_modbus_status_exceptions_tb_top.sv ----
// Testbench for the serial slave: monitor reads, settings and faults.
// Assumes the host model is compiled first; delay tick is shortened.
`timescale 1ns/1ps
module drive_modbus_status_exceptions_tb_top;
   localparam int TICK = 4;
   logic              i_clk;
   logic              i_rst_n;
   logic [3:0]        src;
   logic              req_v;
   mbs_pkg::mbs_req_t req;
   mbs_pkg::mbs_mon_t mon;
   logic              slow, rdy, busy, tv, tl, warn;
   logic [7:0]        td, ecode;
   logic [15:0]       fcmd, nvf;
   logic              nv_v;
   logic [15:0]       nv_f;
   logic [31:0]       seed = 32'h0000_B64C;
   int                miscompares = 0;
   int                comparisons = 0;
   int                dly = 20;
   int                cyc = 0;
   logic [7:0]        eb [0:7];
   logic [7:0]  ex_f [0:6] = '{8'h07, 8'h03, 8'h03, 8'h06,
                               8'h06, 8'h06, 8'h06};
   logic [15:0] ex_a [0:6] = '{16'h2226, 16'h2228, 16'h2226, 16'h0909,
                               16'h090A, 16'h2226, 16'h1234};
   logic [15:0] ex_d [0:6] = '{16'h0001, 16'h0001, 16'h0002, 16'h07D1,
                               16'hE9FD, 16'h0005, 16'h0000};
   logic [7:0]  ex_c [0:6] = '{8'h01, 8'h02, 8'h03, 8'h03,
                               8'h03, 8'h04, 8'h02};
   logic [15:0] ma [0:8] = '{16'h2226, 16'h2227, 16'h2229, 16'h222E, 16'h222F,
                             16'h2230, 16'h2232, 16'h2233, 16'h2234};

   mbs_slave #(.TICK_CYCLES(TICK)) i_mbs_slave (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_node_addr(8'h01), .i_freq_src(src),
      .i_nv_valid(nv_v), .i_nv_freq(nv_f), .i_mon(mon),
      .i_req_valid(req_v), .i_req(req), .o_busy(busy), .o_tx_valid(tv),
      .o_tx_data(td), .o_tx_last(tl), .i_tx_ready(rdy), .o_comm_warn(warn),
      .o_comm_err_code(ecode), .o_freq_cmd(fcmd), .o_nv_freq(nvf));
   mbs_host_model i_mbs_host_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_tx_valid(tv), .i_tx_data(td), .i_tx_last(tl), .i_slow(slow),
      .o_tx_ready(rdy));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] mon_val(input logic [15:0] a);
      case (a)
         16'h2226: return {10'h000, mon.warn, mon.out_active,
                           mon.rdy, mon.dir};
         16'h2227: return mon.torque;
         16'h2229: return mon.energy;
         16'h222E: return mon.loop_tgt;
         16'h222F: return mon.loop_ofs;
         16'h2230: return mon.loop_frq;
         16'h2232: return mon.aux_frq;
         16'h2233: return mon.mas_frq;
         default:  return mon.comb_frq;
      endcase
   endfunction

   function automatic logic [15:0] crc16(input int n);
      logic [15:0] c;
      c = mbs_pkg::CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ {8'h00, eb[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? ((c >> 1) ^ mbs_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic issue(input logic [7:0] f, input logic [15:0] a, d,
                        input logic [7:0] sl, input logic ce);
      logic [31:0] r;
      r = rnd();
      @(posedge i_clk);
      slow  <= r[0];
      req_v <= 1'b1;
      req   <= '{slave: sl, func: f, reg_addr: a, data: d, crc_err: ce};
      @(posedge i_clk);
      req_v <= 1'b0;
   endtask

   // Power cycle: backup storage offers a retained value or nothing
   task automatic pwr_cycle(input logic vld, input logic [15:0] exp_f);
      @(posedge i_clk);
      nv_v    <= vld;
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      chk("nv_rst", nvf, mbs_pkg::RST_FREQ);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      chk("nv_restore", nvf, exp_f);
      @(posedge i_clk);
      #1;
      chk("run_freq", fcmd, exp_f);
   endtask

   // One request and a full check of the reply frame
   task automatic run(input logic [7:0] f, input logic [15:0] a, d,
                      input logic [7:0] code, input logic [15:0] rv);
      int          n;
      int          en;
      logic [7:0]  base;
      logic [15:0] c;
      logic [7:0]  got;
      base = i_mbs_host_model.rx_n_ff;
      issue(f, a, d, 8'h01, 1'b0);
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (tv !== 1'b1 && n < 9000);
      if (!(f == mbs_pkg::FC_WRITE && a == mbs_pkg::ADDR_DELAY))
         chk("latency", n, 2 + dly * TICK);
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      eb[0] = 8'h01;
      if (code != 8'h00) begin
         eb[1] = f | mbs_pkg::FC_EXC_FLAG;
         eb[2] = code;
         en = 3;
      end else if (f == mbs_pkg::FC_READ) begin
         {eb[1], eb[2], eb[3], eb[4]} = {f, mbs_pkg::RD_BYTE_COUNT, rv};
         en = 5;
      end else begin
         {eb[1], eb[2], eb[3], eb[4], eb[5]} = {f, a, d};
         en = 6;
      end
      c = crc16(en);
      {eb[en+1], eb[en]} = c;
      chk("reply_len", 8'(i_mbs_host_model.rx_n_ff - base), en + 2);
      for (int i = 0; i < en + 2; i++) begin
         got = i_mbs_host_model.rx_b_ff[8'(base + i)];
         chk("reply_byte", got, eb[i]);
      end
      chk("last_pos", i_mbs_host_model.last_ff, 8'(base + en + 1));
      chk("warn", warn, code != 8'h00);
      if (code != 8'h00)
         chk("err_code", ecode, code);
   endtask

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      logic [159:0] rr;
      logic [15:0]  v;
      i_rst_n = 1'b0;
      src = 4'h1;
      req_v = 1'b0;
      req = '0;
      mon = '0;
      slow = 1'b0;
      nv_v = 1'b1;
      nv_f = 16'h1234;
      repeat (16) @(posedge i_clk);
      #1;
      chk("nv_rst", nvf, mbs_pkg::RST_FREQ);
      chk("busy_rst", busy, 1'b0);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      chk("nv_restore", nvf, 16'h1234);
      @(posedge i_clk);
      #1;
      chk("run_freq", fcmd, 16'h1234);
      run(8'h03, 16'h0909, 16'h0001, 8'h00, mbs_pkg::RST_DELAY);
      issue(8'h03, 16'h2226, 16'h0001, 8'h01, 1'b1);
      v = 16'h0000;
      repeat (3 + dly * TICK + 20) begin
         @(posedge i_clk);
         #1;
         v[0] = v[0] | tv;
      end
      chk("no_reply", v[0], 1'b0);
      chk("warn_crc", warn, 1'b1);
      chk("crc_code", ecode, mbs_pkg::ERR_CRC);
      issue(8'h03, 16'h2226, 16'h0001, 8'h02, 1'b0);
      @(posedge i_clk);
      #1;
      chk("other_node", busy, 1'b0);
      run(8'h06, 16'h0909, 16'h0003, 8'h00, 16'h0000);
      dly = 3;
      run(8'h03, 16'h0909, 16'h0001, 8'h00, 16'h0003);
      run(8'h06, 16'h0909, mbs_pkg::MAX_DELAY, 8'h00, 16'h0000);
      dly = 2000;
      run(8'h03, 16'h0909, 16'h0001, 8'h00, mbs_pkg::MAX_DELAY);
      run(8'h06, 16'h0909, 16'h0000, 8'h00, 16'h0000);
      dly = 0;
      for (int i = 0; i < 7; i++)
         run(ex_f[i], ex_a[i], ex_d[i], ex_c[i], 16'h0000);
      {eb[0], eb[1], eb[2]} = {8'h01, 8'h86, 8'h02};
      chk("crc_ref", crc16(3), 16'hA1C3);
      @(posedge i_clk);
      src <= 4'h0;
      run(8'h06, 16'h090A, 16'h0100, mbs_pkg::EXC_FAIL, 16'h0000);
      @(posedge i_clk);
      src <= 4'h1;
      run(8'h03, 16'h090A, 16'h0001, 8'h00, 16'h1234);
      for (int i = 0; i < 5; i++) begin
         rr = {rnd(), rnd(), rnd(), rnd(), rnd()};
         v = (i == 0) ? mbs_pkg::MAX_FREQ : 16'(rr[31:0] % 32'd59901);
         run(8'h06, 16'h090A, v, 8'h00, 16'h0000);
         chk("nv_freq", nvf, v);
         chk("freq_cmd", fcmd, v);
         run(8'h03, 16'h090A, 16'h0001, 8'h00, v);
      end
      nv_f <= v;
      pwr_cycle(1'b1, v);
      pwr_cycle(1'b0, mbs_pkg::RST_FREQ);
      run(8'h06, 16'h0909, 16'h0000, 8'h00, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         rr = {rnd(), rnd(), rnd(), rnd(), rnd()};
         @(posedge i_clk);
         mon <= rr[133:0];
         #1;
         foreach (ma[j])
            run(8'h03, ma[j], 16'h0001, 8'h00, mon_val(ma[j]));
      end
      end_of_test();
   end
endmodule // drive_modbus_status_exceptions_tb_top
